/* File: logic/cbs_mul8.sv */
/*
 * Shared package of the bus cycle sequencer (opcodes, cycle counts,
 * addresses, register and bus carriers) and the shift-add multiplier
 * that runs during the internal cycles of the multiply instruction.
 * Assumes one clock, core_clk, and a synchronous active-low reset.
 */
package cbs_pkg;
	localparam logic [15:0] CBS_ADDR_RESTART = 16'hffff;
	localparam logic [15:0] CBS_VEC_SWI = 16'hfffa;
	localparam logic [15:0] CBS_VEC_RESET = 16'hfffe;
	localparam logic [15:0] CBS_ONE = 16'h0001;
	localparam logic [15:0] CBS_TWO = 16'h0002;
	localparam logic [15:0] CBS_FRAME_BYTES = 16'h0007;
	localparam logic [15:0] CBS_LAST_PUSH = 16'h0006;
	localparam logic [7:0] WAIT_FOR_INTERRUPT_INSTR = 8'h3e;
	localparam logic [7:0] MULTIPLY_INSTR = 8'h3d;
	localparam logic [7:0] RETURN_FROM_INTERRUPT_INSTR = 8'h3b;
	localparam logic [7:0] SOFTWARE_INTERRUPT_INSTR = 8'h3f;
	localparam logic [7:0] BRANCH_TO_SUBROUTINE_INSTR = 8'h8d;
	localparam logic [7:0] BRANCH_ALWAYS_INSTR = 8'h20;
	localparam logic [7:0] BRANCH_NEVER_INSTR = 8'h21;
	localparam logic [7:0] BRANCH_CARRY_CLEAR_INSTR = 8'h24;
	localparam logic [7:0] BRANCH_EQUAL_INSTR = 8'h27;
	localparam logic [3:0] CBS_BRANCH_GROUP = 4'h2;
	// cycle numbers, counted from 1 at the opcode fetch
	localparam logic [3:0] CBS_CYC_FIRST = 4'h1;
	localparam logic [3:0] CBS_CYC_SECOND = 4'h2;
	localparam logic [3:0] CBS_CYC_THIRD = 4'h3;
	localparam logic [3:0] CBS_CYC_FOURTH = 4'h4;
	localparam logic [3:0] CBS_CYC_FIFTH = 4'h5;
	localparam logic [3:0] CBS_CYC_SAVE_END = 4'h9;
	localparam logic [3:0] CBS_CYC_SWI_DUMMY = 4'ha;
	localparam logic [3:0] CBS_CYC_SWI_VHI = 4'hb;
	localparam logic [3:0] CBS_CYC_PCH = 4'h9;
	localparam logic [3:0] CBS_CYC_PCL = 4'ha;
	localparam logic [3:0] CBS_LEN_WAIT = 4'h9;
	localparam logic [3:0] CBS_LEN_MUL = 4'ha;
	localparam logic [3:0] CBS_LEN_RTI = 4'ha;
	localparam logic [3:0] CBS_LEN_SWI = 4'hc;
	localparam logic [3:0] CBS_LEN_BSR = 4'h6;
	localparam logic [3:0] CBS_LEN_BR = 4'h3;
	localparam logic [3:0] CBS_LEN_OTHER = 4'h2;
	localparam logic [3:0] CBS_MUL_STEPS = 4'h8;
	// condition code bit positions
	localparam int CBS_CC_C = 0;
	localparam int CBS_CC_V = 1;
	localparam int CBS_CC_Z = 2;
	localparam int CBS_CC_N = 3;
	localparam int CBS_CC_I = 4;
	localparam logic [7:0] CBS_CCR_RESET = 8'h10;

	typedef enum logic [3:0] {
		CBS_ST_FETCH = 4'h1,
		CBS_ST_EXEC = 4'h2,
		CBS_ST_WAIT = 4'h4,
		CBS_ST_VEC = 4'h8
	} cbs_state_t;

	typedef enum logic [2:0] {
		CBS_K_OTHER = 3'h0,
		CBS_K_WAIT = 3'h1,
		CBS_K_MUL = 3'h2,
		CBS_K_RTI = 3'h3,
		CBS_K_SWI = 3'h4,
		CBS_K_BSR = 3'h5,
		CBS_K_BR = 3'h6
	} cbs_kind_t;

	typedef struct packed {
		logic [15:0] addr;
		logic rw;
		logic [7:0] dout;
	} cbs_bus_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] x;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] ccr;
	} cbs_regs_t;
endpackage

`timescale 1ns/1ns
module cbs_mul8 (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] mcand,
	input wire logic [7:0] mplier,
	output logic [15:0] product
);
	logic [15:0] acc_reg;
	logic [7:0] mcand_reg;
	logic [3:0] left_reg;
	logic [8:0] sum;
	logic [15:0] stepped;

	// one shift-add step per internal bus cycle
	assign sum = {1'b0, acc_reg[15:8]} + {1'b0, mcand_reg};
	assign stepped = acc_reg[0] ? {sum, acc_reg[7:1]} :
		{1'b0, acc_reg[15:1]};
	assign product = acc_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acc_reg <= 16'h0000;
			mcand_reg <= 8'h00;
			left_reg <= 4'h0;
		end else if (start) begin
			acc_reg <= {8'h00, mplier};
			mcand_reg <= mcand;
			left_reg <= cbs_pkg::CBS_MUL_STEPS;
		end else if (left_reg != 4'h0) begin
			acc_reg <= stepped;
			left_reg <= left_reg - 4'h1;
		end
	end
endmodule

/* File: logic/cbs_sequencer.sv */
/*
 * Cycle-by-cycle bus sequencer of the processor core: drives address,
 * read/write and write data for the wait, multiply, return, software
 * interrupt, relative branch and branch-to-subroutine sequences; other
 * opcodes run as two-cycle implied instructions.
 * Assumes memory answers a read within the cycle that bus shows and that
 * irq_req is already masked and prioritised, with its vector on irq_vector.
 */
`timescale 1ns/1ns
module cbs_sequencer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] bus_din,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	output cbs_pkg::cbs_bus_t bus,
	output logic bus_doe,
	output logic port_drive_en,
	output cbs_pkg::cbs_regs_t regs,
	output logic instr_done
);
	cbs_pkg::cbs_state_t state_reg, state_next;
	cbs_pkg::cbs_kind_t kind_reg, kind_next;
	cbs_pkg::cbs_regs_t regs_reg, regs_next;
	cbs_pkg::cbs_bus_t bus_reg, bus_next;
	logic [3:0] cyc_reg, cyc_next;
	logic [7:0] opcode_reg, off_reg;
	logic [15:0] vec_reg, vec_next;
	logic doe_reg, port_en_reg, done_reg, done_next;
	logic [15:0] product, target, br_pc;
	logic mul_start, taken, last;

	function automatic cbs_pkg::cbs_kind_t decode(input logic [7:0] op);
		case (op)
			cbs_pkg::WAIT_FOR_INTERRUPT_INSTR: decode = cbs_pkg::CBS_K_WAIT;
			cbs_pkg::MULTIPLY_INSTR: decode = cbs_pkg::CBS_K_MUL;
			cbs_pkg::RETURN_FROM_INTERRUPT_INSTR: decode = cbs_pkg::CBS_K_RTI;
			cbs_pkg::SOFTWARE_INTERRUPT_INSTR: decode = cbs_pkg::CBS_K_SWI;
			cbs_pkg::BRANCH_TO_SUBROUTINE_INSTR: decode = cbs_pkg::CBS_K_BSR;
			default: decode = (op[7:4] == cbs_pkg::CBS_BRANCH_GROUP) ?
				cbs_pkg::CBS_K_BR : cbs_pkg::CBS_K_OTHER;
		endcase
	endfunction

	function automatic logic [3:0] seq_len(input cbs_pkg::cbs_kind_t k);
		case (k)
			cbs_pkg::CBS_K_WAIT: seq_len = cbs_pkg::CBS_LEN_WAIT;
			cbs_pkg::CBS_K_MUL: seq_len = cbs_pkg::CBS_LEN_MUL;
			cbs_pkg::CBS_K_RTI: seq_len = cbs_pkg::CBS_LEN_RTI;
			cbs_pkg::CBS_K_SWI: seq_len = cbs_pkg::CBS_LEN_SWI;
			cbs_pkg::CBS_K_BSR: seq_len = cbs_pkg::CBS_LEN_BSR;
			cbs_pkg::CBS_K_BR: seq_len = cbs_pkg::CBS_LEN_BR;
			default: seq_len = cbs_pkg::CBS_LEN_OTHER;
		endcase
	endfunction

	// pairs of conditions; odd low bit inverts the even one
	function automatic logic cond(input logic [3:0] sel,
			input logic [7:0] cc);
		logic base;
		base = 1'b1;
		case (sel[3:1])
			3'h0: base = 1'b1;
			3'h1: base = !(cc[cbs_pkg::CBS_CC_C] | cc[cbs_pkg::CBS_CC_Z]);
			3'h2: base = !cc[cbs_pkg::CBS_CC_C];
			3'h3: base = !cc[cbs_pkg::CBS_CC_Z];
			3'h4: base = !cc[cbs_pkg::CBS_CC_V];
			3'h5: base = !cc[cbs_pkg::CBS_CC_N];
			3'h6: base = !(cc[cbs_pkg::CBS_CC_N] ^ cc[cbs_pkg::CBS_CC_V]);
			default: base = !(cc[cbs_pkg::CBS_CC_Z] |
				(cc[cbs_pkg::CBS_CC_N] ^ cc[cbs_pkg::CBS_CC_V]));
		endcase
		cond = base ^ sel[0];
	endfunction

	// byte pushed k places below the stack pointer in a context save
	function automatic logic [7:0] save_byte(input logic [3:0] k,
			input cbs_pkg::cbs_regs_t r, input logic [15:0] ret);
		case (k)
			4'h0: save_byte = ret[7:0];
			4'h1: save_byte = ret[15:8];
			4'h2: save_byte = r.x[7:0];
			4'h3: save_byte = r.x[15:8];
			4'h4: save_byte = r.a;
			4'h5: save_byte = r.b;
			default: save_byte = r.ccr;
		endcase
	endfunction

	// what the bus shows in a given state and cycle
	function automatic cbs_pkg::cbs_bus_t plan(input cbs_pkg::cbs_state_t st,
			input logic [3:0] cyc, input cbs_pkg::cbs_kind_t k,
			input cbs_pkg::cbs_regs_t r, input logic [15:0] tgt,
			input logic [15:0] vec);
		cbs_pkg::cbs_bus_t p;
		logic [15:0] ret;
		logic [3:0] k3;
		p = '{addr: r.pc, rw: 1'b1, dout: 8'h00};
		ret = r.pc + ((k == cbs_pkg::CBS_K_BSR) ? cbs_pkg::CBS_TWO :
			cbs_pkg::CBS_ONE);
		k3 = cyc - cbs_pkg::CBS_CYC_THIRD;
		case (st)
			cbs_pkg::CBS_ST_WAIT: p.addr = r.sp;
			cbs_pkg::CBS_ST_VEC: p.addr = (cyc == cbs_pkg::CBS_CYC_FIRST) ?
				vec : vec + cbs_pkg::CBS_ONE;
			cbs_pkg::CBS_ST_EXEC: begin
				if (cyc == cbs_pkg::CBS_CYC_SECOND) begin
					p.addr = r.pc + cbs_pkg::CBS_ONE;
				end else begin
					case (k)
						cbs_pkg::CBS_K_WAIT, cbs_pkg::CBS_K_SWI: begin
							if (cyc <= cbs_pkg::CBS_CYC_SAVE_END) begin
								p.addr = r.sp - {12'h000, k3};
								p.rw = 1'b0;
								p.dout = save_byte(k3, r, ret);
							end else if (cyc == cbs_pkg::CBS_CYC_SWI_DUMMY) begin
								p.addr = r.sp - cbs_pkg::CBS_FRAME_BYTES;
							end else if (cyc == cbs_pkg::CBS_CYC_SWI_VHI) begin
								p.addr = cbs_pkg::CBS_VEC_SWI;
							end else begin
								p.addr = cbs_pkg::CBS_VEC_SWI + cbs_pkg::CBS_ONE;
							end
						end
						cbs_pkg::CBS_K_RTI: p.addr = (cyc == cbs_pkg::CBS_CYC_THIRD) ?
							r.sp : r.sp + {12'h000, k3};
						cbs_pkg::CBS_K_BSR: begin
							if (cyc == cbs_pkg::CBS_CYC_FOURTH) begin
								p.addr = tgt;
							end else if (cyc >= cbs_pkg::CBS_CYC_FIFTH) begin
								p.addr = r.sp - {12'h000, cyc - cbs_pkg::CBS_CYC_FIFTH};
								p.rw = 1'b0;
								p.dout = (cyc == cbs_pkg::CBS_CYC_FIFTH) ?
									ret[7:0] : ret[15:8];
							end else begin
								p.addr = cbs_pkg::CBS_ADDR_RESTART;
							end
						end
						default: p.addr = cbs_pkg::CBS_ADDR_RESTART;
					endcase
				end
			end
			default: p.addr = r.pc;
		endcase
		plan = p;
	endfunction

	assign kind_next = (state_reg == cbs_pkg::CBS_ST_FETCH) ?
		decode(bus_din) : kind_reg;
	assign last = (state_reg == cbs_pkg::CBS_ST_EXEC) &&
		(cyc_reg == seq_len(kind_reg));
	assign target = regs_reg.pc + cbs_pkg::CBS_TWO + {{8{off_reg[7]}}, off_reg};
	assign taken = cond(opcode_reg[3:0], regs_reg.ccr);
	assign br_pc = taken ? target : regs_reg.pc + cbs_pkg::CBS_TWO;
	assign mul_start = (state_reg == cbs_pkg::CBS_ST_FETCH) &&
		(decode(bus_din) == cbs_pkg::CBS_K_MUL);
	assign vec_next = (state_reg == cbs_pkg::CBS_ST_WAIT && irq_req) ?
		irq_vector : vec_reg;
	assign bus_next = plan(state_next, cyc_next, kind_next, regs_next,
		target, vec_next);

	cbs_mul8 u_mul (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(mul_start),
		.mcand(regs_reg.a),
		.mplier(regs_reg.b),
		.product(product)
	);

	always_comb begin
		state_next = state_reg;
		cyc_next = cyc_reg + 4'h1;
		regs_next = regs_reg;
		done_next = 1'b0;
		case (state_reg)
			cbs_pkg::CBS_ST_FETCH: begin
				state_next = cbs_pkg::CBS_ST_EXEC;
				cyc_next = cbs_pkg::CBS_CYC_SECOND;
			end
			cbs_pkg::CBS_ST_EXEC: begin
				if (kind_reg == cbs_pkg::CBS_K_RTI) begin
					case (cyc_reg)
						4'h4: regs_next.ccr = bus_din;
						4'h5: regs_next.b = bus_din;
						4'h6: regs_next.a = bus_din;
						4'h7: regs_next.x[15:8] = bus_din;
						4'h8: regs_next.x[7:0] = bus_din;
						4'h9: regs_next.pc[15:8] = bus_din;
						4'ha: regs_next.pc[7:0] = bus_din;
						default: regs_next = regs_reg;
					endcase
				end
				if (kind_reg == cbs_pkg::CBS_K_SWI) begin
					if (cyc_reg == cbs_pkg::CBS_CYC_SWI_VHI) begin
						regs_next.pc[15:8] = bus_din;
					end else if (cyc_reg == cbs_pkg::CBS_LEN_SWI) begin
						regs_next.pc[7:0] = bus_din;
					end
				end
				if (last) begin
					state_next = (kind_reg == cbs_pkg::CBS_K_WAIT) ?
						cbs_pkg::CBS_ST_WAIT : cbs_pkg::CBS_ST_FETCH;
					cyc_next = cbs_pkg::CBS_CYC_FIRST;
					done_next = (kind_reg != cbs_pkg::CBS_K_WAIT);
					case (kind_reg)
						cbs_pkg::CBS_K_WAIT: begin
							regs_next.sp = regs_reg.sp - cbs_pkg::CBS_FRAME_BYTES;
						end
						cbs_pkg::CBS_K_SWI: begin
							regs_next.sp = regs_reg.sp - cbs_pkg::CBS_FRAME_BYTES;
							regs_next.ccr[cbs_pkg::CBS_CC_I] = 1'b1;
						end
						cbs_pkg::CBS_K_RTI: begin
							regs_next.sp = regs_reg.sp + cbs_pkg::CBS_FRAME_BYTES;
						end
						cbs_pkg::CBS_K_BSR: begin
							regs_next.sp = regs_reg.sp - cbs_pkg::CBS_TWO;
							regs_next.pc = target;
						end
						cbs_pkg::CBS_K_BR: regs_next.pc = br_pc;
						cbs_pkg::CBS_K_MUL: begin
							regs_next.pc = regs_reg.pc + cbs_pkg::CBS_ONE;
							regs_next.a = product[15:8];
							regs_next.b = product[7:0];
							regs_next.ccr[cbs_pkg::CBS_CC_C] = product[7];
						end
						default: regs_next.pc = regs_reg.pc + cbs_pkg::CBS_ONE;
					endcase
				end
			end
			cbs_pkg::CBS_ST_WAIT: begin
				// no save here: the frame is already on the stack
				cyc_next = cyc_reg;
				if (irq_req) begin
					state_next = cbs_pkg::CBS_ST_VEC;
					cyc_next = cbs_pkg::CBS_CYC_FIRST;
				end
			end
			cbs_pkg::CBS_ST_VEC: begin
				if (cyc_reg == cbs_pkg::CBS_CYC_FIRST) begin
					regs_next.pc[15:8] = bus_din;
				end else begin
					regs_next.pc[7:0] = bus_din;
					regs_next.ccr[cbs_pkg::CBS_CC_I] = 1'b1;
					state_next = cbs_pkg::CBS_ST_FETCH;
					cyc_next = cbs_pkg::CBS_CYC_FIRST;
					done_next = 1'b1;
				end
			end
			default: begin
				state_next = cbs_pkg::CBS_ST_FETCH;
				cyc_next = cbs_pkg::CBS_CYC_FIRST;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= cbs_pkg::CBS_ST_VEC;
			cyc_reg <= cbs_pkg::CBS_CYC_FIRST;
			kind_reg <= cbs_pkg::CBS_K_OTHER;
			regs_reg <= '{pc: 16'h0000, sp: 16'h0000, x: 16'h0000,
				a: 8'h00, b: 8'h00, ccr: cbs_pkg::CBS_CCR_RESET};
			bus_reg <= '{addr: cbs_pkg::CBS_VEC_RESET, rw: 1'b1, dout: 8'h00};
			vec_reg <= cbs_pkg::CBS_VEC_RESET;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cyc_reg <= cyc_next;
			kind_reg <= kind_next;
			regs_reg <= regs_next;
			bus_reg <= bus_next;
			vec_reg <= vec_next;
			done_reg <= done_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			opcode_reg <= 8'h00;
			off_reg <= 8'h00;
			doe_reg <= 1'b0;
			port_en_reg <= 1'b0;
		end else begin
			if (state_reg == cbs_pkg::CBS_ST_FETCH) begin
				opcode_reg <= bus_din;
			end
			if (state_reg == cbs_pkg::CBS_ST_EXEC &&
					cyc_reg == cbs_pkg::CBS_CYC_SECOND) begin
				off_reg <= bus_din;
			end
			doe_reg <= !bus_next.rw;
			// ports stay driven in every state, wait included
			port_en_reg <= 1'b1;
		end
	end

	assign bus = bus_reg;
	assign bus_doe = doe_reg;
	assign port_drive_en = port_en_reg;
	assign regs = regs_reg;
	assign instr_done = done_reg;

	sequence s_wait_save;
		(!bus_reg.rw)[*7] ##1 (state_reg == cbs_pkg::CBS_ST_WAIT);
	endsequence
	sequence s_swi_tail;
		(bus_reg.rw && bus_reg.addr == regs_reg.sp - 16'h0007) ##1
		(bus_reg.addr == 16'hfffa) ##1 (bus_reg.addr == 16'hfffb);
	endsequence

	property p_wait_len;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_WAIT
			&& cyc_reg == cbs_pkg::CBS_CYC_THIRD) |-> s_wait_save;
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("wait save wrong");
	property p_wait_ret;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_WAIT
			&& cyc_reg == cbs_pkg::CBS_CYC_THIRD) |->
		(bus_reg.addr == regs_reg.sp && bus_reg.dout == regs_reg.pc[7:0] +
			8'h01) ##1 (bus_reg.addr == regs_reg.sp - 16'h0001);
	endproperty
	a_wait_ret: assert property (p_wait_ret) else $error("wait return push");
	property p_wait_ccr;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_WAIT
			&& cyc_reg == cbs_pkg::CBS_LEN_WAIT) |->
		(bus_reg.dout == regs_reg.ccr && bus_reg.addr == regs_reg.sp - 16'h0006);
	endproperty
	a_wait_ccr: assert property (p_wait_ccr) else $error("wait ccr push");
	property p_wait_addr;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_WAIT && $past(state_reg, 7) ==
			cbs_pkg::CBS_ST_EXEC && $past(cyc_reg, 7) == 4'h3) |->
		(bus_reg.rw && bus_reg.addr == $past(regs_reg.sp, 7) - 16'h0007);
	endproperty
	a_wait_addr: assert property (p_wait_addr) else $error("wait address");
	property p_ports;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_WAIT) |-> port_drive_en;
	endproperty
	a_ports: assert property (p_ports) else $error("ports floated");
	property p_mul;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_MUL
			&& cyc_reg == cbs_pkg::CBS_CYC_THIRD) |->
		(bus_reg.rw && bus_reg.addr == 16'hffff)[*8] ##1
		(state_reg == cbs_pkg::CBS_ST_FETCH);
	endproperty
	a_mul: assert property (p_mul) else $error("multiply cycles");
	property p_branch;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_BR
			&& cyc_reg == cbs_pkg::CBS_CYC_THIRD) |->
		(bus_reg.addr == 16'hffff && bus_reg.rw) ##1
		(state_reg == cbs_pkg::CBS_ST_FETCH);
	endproperty
	a_branch: assert property (p_branch) else $error("branch cycles");
	property p_rti_pc;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_RTI
			&& cyc_reg == cbs_pkg::CBS_CYC_PCL) |=>
		(regs_reg.pc == {$past(bus_din, 2), $past(bus_din)} &&
			bus_reg.addr == regs_reg.pc);
	endproperty
	a_rti_pc: assert property (p_rti_pc) else $error("return pc");
	property p_swi_tail;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_SWI
			&& cyc_reg == cbs_pkg::CBS_CYC_SWI_DUMMY) |-> s_swi_tail;
	endproperty
	a_swi_tail: assert property (p_swi_tail) else $error("swi vector");
	property p_bsr_push;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_EXEC && kind_reg == cbs_pkg::CBS_K_BSR
			&& cyc_reg == cbs_pkg::CBS_CYC_FIFTH) |->
		(!bus_reg.rw && bus_reg.addr == regs_reg.sp) ##1
		(!bus_reg.rw && bus_reg.addr == regs_reg.sp - 16'h0001) ##1
		(state_reg == cbs_pkg::CBS_ST_FETCH);
	endproperty
	a_bsr_push: assert property (p_bsr_push) else $error("bsr push");
	property p_wait_exit;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == cbs_pkg::CBS_ST_WAIT && irq_req) |=>
		(state_reg == cbs_pkg::CBS_ST_VEC && bus_reg.rw &&
			bus_reg.addr == $past(irq_vector));
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("wait exit");
endmodule

/* File: tb/cbs_mem_model.sv */
/*
 * Behavioural bus memory for the sequencer bench: 64k bytes, zero wait.
 * Assumes one bus cycle per core_clk edge and data enable on writes.
 */
`timescale 1ns/1ns
module cbs_mem_model (
	input wire logic core_clk,
	input cbs_pkg::cbs_bus_t bus,
	input wire logic bus_doe,
	output logic [7:0] bus_din
);
	logic [7:0] mem [0:65535] = '{default: 8'h00};
	logic [7:0] last_reg = 8'h00;
	// off-cycle data is the inverse of the last byte, never a stale copy
	assign bus_din = bus.rw ? mem[bus.addr] : ~last_reg;
	// plain always: the bench preloads mem by hierarchical writes
	always @(posedge core_clk) begin
		last_reg <= bus_din;
		if (bus_doe && !bus.rw) begin
			mem[bus.addr] <= bus.dout;
		end
	end
endmodule

/* File: tb/test_cpu_bus_cycle_sequencer.sv */
/*
 * Self-checking bench: one program walks return, multiply, branches,
 * subroutine branch, software interrupt and wait, cycle by cycle.
 * Assumes cbs_pkg and cbs_mem_model are compiled first.
 */
`timescale 1ns/1ns
module test_cpu_bus_cycle_sequencer;
	logic core_clk;
	logic rst_n;
	logic irq_req;
	logic [15:0] irq_vector;
	logic [7:0] bus_din;
	cbs_pkg::cbs_bus_t bus;
	logic bus_doe;
	logic port_drive_en;
	cbs_pkg::cbs_regs_t regs;
	logic instr_done;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;

	cbs_sequencer i_dut (.core_clk(core_clk), .rst_n(rst_n),
		.bus_din(bus_din), .irq_req(irq_req), .irq_vector(irq_vector),
		.bus(bus), .bus_doe(bus_doe), .port_drive_en(port_drive_en),
		.regs(regs), .instr_done(instr_done));
	cbs_mem_model i_mem (.core_clk(core_clk), .bus(bus),
		.bus_doe(bus_doe), .bus_din(bus_din));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// generous ceiling; the program needs under 100 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one bus cycle, looked at mid-cycle once the edge has settled
	task automatic bc(input logic [15:0] a, input logic rd,
		input logic [7:0] d, input logic chkd);
		@(negedge core_clk);
		chk("addr", a, bus.addr);
		chk("rw_doe", {14'h0, rd, !rd}, {14'h0, bus.rw, bus_doe});
		if (chkd) begin
			chk("dout", {8'h00, d}, {8'h00, bus.dout});
		end
	endtask

	task automatic rds(input logic [15:0] a, input int n, input logic inc);
		for (int i = 0; i < n; i++) begin
			bc(inc ? a + 16'(i) : a, 1'b1, 8'h00, 1'b0);
		end
	endtask

	// registered outputs seen just after the edge that ends a sequence
	task automatic settle;
		@(posedge core_clk);
		#1;
	endtask

	// condition codes go last, at the lowest address of the frame
	task automatic push7(input logic [15:0] sp0, input logic [15:0] ret,
		input logic [7:0] cc);
		logic [7:0] d [0:5];
		d = '{ret[7:0], ret[15:8], 8'h34, 8'h12, 8'h00, 8'h0f};
		for (int i = 0; i < 6; i++) begin
			bc(sp0 - 16'(i), 1'b0, d[i], 1'b1);
		end
		bc(sp0 - 16'h0006, 1'b0, cc, 1'b1);
	endtask

	task automatic put(input logic [15:0] a, input logic [7:0] d);
		i_mem.mem[a] = d;
	endtask

	task automatic t_rti;
		rds(16'h0100, 2, 1'b1);
		rds(16'h0000, 8, 1'b1);
		settle();
		chk("ab", 16'h0305, {regs.a, regs.b});
		chk("x", 16'h1234, regs.x);
		chk("sp", 16'h0007, regs.sp);
	endtask

	task automatic t_mul;
		rds(16'h0200, 2, 1'b1);
		rds(16'hffff, 8, 1'b0);
		settle();
		chk("ab", 16'h000f, {regs.a, regs.b});
		chk("done", 16'h0001, {15'h0, instr_done});
	endtask

	// always, never, carry clear taken, equal with zero offset
	task automatic t_br;
		logic [15:0] pcs [0:3];
		pcs = '{16'h0201, 16'h0205, 16'h0207, 16'h020d};
		for (int i = 0; i < 4; i++) begin
			rds(pcs[i], 2, 1'b1);
			bc(16'hffff, 1'b1, 8'h00, 1'b0);
		end
	endtask

	task automatic t_bsr;
		rds(16'h020f, 2, 1'b1);
		bc(16'hffff, 1'b1, 8'h00, 1'b0);
		bc(16'h0221, 1'b1, 8'h00, 1'b0);
		bc(16'h0007, 1'b0, 8'h11, 1'b1);
		bc(16'h0006, 1'b0, 8'h02, 1'b1);
		settle();
		chk("sp", 16'h0005, regs.sp);
	endtask

	// frame runs through address zero and wraps to ffff
	task automatic t_swi;
		rds(16'h0221, 2, 1'b1);
		push7(16'h0005, 16'h0222, 8'h00);
		bc(16'hfffe, 1'b1, 8'h00, 1'b0);
		rds(16'hfffa, 2, 1'b1);
		settle();
		chk("sp", 16'hfffe, regs.sp);
	endtask

	task automatic t_wait;
		rds(16'h0300, 2, 1'b1);
		push7(16'hfffe, 16'h0301, 8'h10);
		rds(16'hfff7, 6, 1'b0);
		chk("done", 16'h0000, {15'h0, instr_done});
		chk("sp", 16'hfff7, regs.sp);
		chk("port_en", 16'h0001, {15'h0, port_drive_en});
		@(posedge core_clk);
		irq_vector <= 16'h0400;
		irq_req <= 1'b1;
		bc(16'hfff7, 1'b1, 8'h00, 1'b0);
		@(posedge core_clk);
		irq_req <= 1'b0;
		rds(16'h0400, 2, 1'b1);
		bc(16'h0500, 1'b1, 8'h00, 1'b0);
		chk("port_en", 16'h0001, {15'h0, port_drive_en});
	endtask

	initial begin
		rst_n = 1'b0;
		irq_req = 1'b0;
		irq_vector = 16'h0000;
		put(16'hfffe, 8'h01);
		put(16'hfffa, 8'h03);
		put(16'h0002, 8'h05);
		put(16'h0003, 8'h03);
		put(16'h0004, 8'h12);
		put(16'h0005, 8'h34);
		put(16'h0006, 8'h02);
		put(16'h0100, cbs_pkg::RETURN_FROM_INTERRUPT_INSTR);
		put(16'h0200, cbs_pkg::MULTIPLY_INSTR);
		put(16'h0201, cbs_pkg::BRANCH_ALWAYS_INSTR);
		put(16'h0202, 8'h02);
		put(16'h0205, cbs_pkg::BRANCH_NEVER_INSTR);
		put(16'h0206, 8'h10);
		put(16'h0207, cbs_pkg::BRANCH_CARRY_CLEAR_INSTR);
		put(16'h0208, 8'h04);
		put(16'h020d, cbs_pkg::BRANCH_EQUAL_INSTR);
		put(16'h020f, cbs_pkg::BRANCH_TO_SUBROUTINE_INSTR);
		put(16'h0210, 8'h10);
		put(16'h0221, cbs_pkg::SOFTWARE_INTERRUPT_INSTR);
		put(16'h0300, cbs_pkg::WAIT_FOR_INTERRUPT_INSTR);
		put(16'h0400, 8'h05);
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		// align on the low vector read that precedes the first fetch
		for (int i = 0; i < 8 && bus.addr !== 16'hffff; i++) begin
			@(negedge core_clk);
		end
		t_rti();
		t_mul();
		t_br();
		t_bsr();
		t_swi();
		t_wait();
		print_verdict();
	end
endmodule
